// File: shared/poa_pkg.sv
// poa_pkg: constants and types shared by the instrument end and controller end
// assumes: both ends run on i_mclk at 40 MHz
package poa_pkg;
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned FLASH_MS     = 250;   // indicator half period
  localparam int unsigned FLASH_CYC    = (CLK_HZ / 1000) * FLASH_MS;
  localparam int unsigned PWM_HZ       = 2000;  // buzzer tone
  localparam int unsigned PWM_CYC      = CLK_HZ / (2 * PWM_HZ);
  localparam int unsigned EVAL_US      = 10;    // least evaluation phase
  localparam int unsigned EVAL_CYC     = (CLK_HZ / 1000000) * EVAL_US;
  localparam int unsigned NUM_SW       = 6;
  localparam int unsigned RD_W         = 16;    // signed channel reading width
  localparam int unsigned NUM_PROG     = 16;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned CTR_W        = 24;
  localparam logic [7:0]  PCT_FULL     = 8'h64; // one hundred percent

  // switch configuration fields
  typedef struct packed {
    logic            chan_y;      // 0: x channel, 1: y channel
    logic            ref_trig;    // x only: 1 trigger reference
    logic            act_high;
    logic [RD_W-1:0] thresh;
  } poa_sw_cfg_t;

  typedef enum logic [2:0] {
    POA_IDLE, POA_MEAS, POA_EVAL, POA_ACKW, POA_STAT
  } poa_state_t;
endpackage : poa_pkg

// File: shared/poa_if.sv
// poa_if: discrete lines between the instrument and the controller
// assumes: both ends share i_mclk; the bench joins the two modports
`timescale 1ns/1ps
`default_nettype none
interface poa_if;
  import poa_pkg::*;
  logic              start;
  logic              stat_reset;
  logic              operator_fail_acknowledge_in;
  logic              ready;
  logic              verdict_ok_out;
  logic              verdict_fail_out;
  logic              online_window_violation;
  logic              fail_indicator_lamp;
  logic              lock_out;
  logic              buzzer_out;
  logic [NUM_SW-1:0] switch_out;

  modport instr (input start, stat_reset, operator_fail_acknowledge_in,
                 output ready, verdict_ok_out, verdict_fail_out, online_window_violation,
                 fail_indicator_lamp, lock_out, buzzer_out, switch_out);
  modport ctrl (output start, stat_reset, operator_fail_acknowledge_in,
                input ready, verdict_ok_out, verdict_fail_out, online_window_violation,
                fail_indicator_lamp, lock_out, buzzer_out, switch_out);
endinterface : poa_if
`default_nettype wire

// File: src/poa_instr.sv
// poa_instr: instrument end, online flag, switch outputs, acknowledge, statistics reset
// assumes: link inputs come from another party and are synchronised here;
// readings, verdicts and config come from the same-clock measurement engine
//
// Behaviour
// - controller checks ready before starting
// - controller starts measurement with start high
// - online violation low during measurement
// - incorrect window exit raises online violation
// - correct crossing leaves online violation low
// - forbidden edge exit drives violation high
// - violation cleared at next measurement start
// - six switch outputs from threshold compare
// - x absolute output follows reading above threshold
// - absolute reference is sensor zero point
// - absolute x updated idle and measuring
// - trigger x only after trigger, relative
// - y output follows threshold, idle and measuring
// - fail plus ack enabled: flash, lock, buzz
// - acknowledge: lamp steady, lock and buzzer off
// - lamp stays on until next start
// - stat reset only while ready; ready drops
// - controller releases stat reset after ready low
// - stat reset clears counters of every program
// - stat reset clears percentage of every program
// - measuring: both verdicts high, ready low
`timescale 1ns/1ps
`default_nettype none
module poa_instr
  import poa_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_arst_n,
  poa_if.instr                        link,
  input  wire logic                   i_ack_fail_en,
  input  wire logic                   i_eval_done,
  input  wire logic                   i_eval_fail,
  input  wire logic                   i_win_exit_bad,
  input  wire logic                   i_trig_seen,
  input  wire logic signed [RD_W-1:0] i_x_abs,
  input  wire logic signed [RD_W-1:0] i_x_trig,
  input  wire logic signed [RD_W-1:0] i_y,
  input  wire poa_sw_cfg_t            i_sw_cfg [NUM_SW],
  input  wire logic [3:0]             i_prog_sel,
  input  wire logic                   i_part_done,
  output logic [CNT_W-1:0]            o_part_cnt,
  output logic [CNT_W-1:0]            o_fail_cnt,
  output logic [7:0]                  o_fail_pct
);
  typedef struct packed {
    poa_state_t        st;
    logic [1:0]        s_start;
    logic [1:0]        s_rst;
    logic [1:0]        s_ack;
    logic              ready;
    logic              ok;
    logic              fail;
    logic              onl;
    logic              lamp_on;
    logic              flash;
    logic              lock;
    logic              buzz;
    logic [CTR_W-1:0]  fl_cnt;
    logic [CTR_W-1:0]  pw_cnt;
    logic [CTR_W-1:0]  ev_cnt;
    logic [NUM_SW-1:0] sw;
  } poa_st_t;

  poa_st_t s_q;
  poa_st_t s_d;

  // statistics memory, one entry per program
  logic [CNT_W-1:0] part_mem_q [NUM_PROG];
  logic [CNT_W-1:0] fail_mem_q [NUM_PROG];
  logic [7:0]       pct_mem_q  [NUM_PROG];
  logic             clr_all;
  logic [NUM_SW-1:0] cmp;
  logic              meas_act;

  assign meas_act = (s_q.st == POA_MEAS);

  ////////////////////////////////////////////////////////////////////////////
  // threshold compare per switch output
  genvar g;
  generate
    for (g = 0; g < NUM_SW; g++) begin : g_sw
      logic signed [RD_W-1:0] rd;
      logic                   en;
      always_comb begin
        rd = i_sw_cfg[g].chan_y ? i_y : (i_sw_cfg[g].ref_trig ? i_x_trig : i_x_abs);
        en = i_sw_cfg[g].chan_y || !i_sw_cfg[g].ref_trig || (meas_act && i_trig_seen);
      end
      assign cmp[g] = en ? ((rd > $signed(i_sw_cfg[g].thresh)) == i_sw_cfg[g].act_high)
                         : !i_sw_cfg[g].act_high;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d         = s_q;
    clr_all     = 1'b0;
    s_d.s_start = {s_q.s_start[0], link.start};
    s_d.s_rst   = {s_q.s_rst[0], link.stat_reset};
    s_d.s_ack   = {s_q.s_ack[0], link.operator_fail_acknowledge_in};
    s_d.sw      = cmp;
    // flash timer runs free; pwm timer runs in every state but restarts when lock is set; buzz toggles only while locked
    if (s_q.fl_cnt >= CTR_W'(FLASH_CYC - 1)) begin
      s_d.fl_cnt = '0;
      s_d.flash  = !s_q.flash;
    end else begin
      s_d.fl_cnt = s_q.fl_cnt + 1'b1;
    end
    if (s_q.pw_cnt >= CTR_W'(PWM_CYC - 1)) begin
      s_d.pw_cnt = '0;
    end else begin
      s_d.pw_cnt = s_q.pw_cnt + 1'b1;
    end
    if (s_q.lock && s_q.pw_cnt == '0) begin
      s_d.buzz = !s_q.buzz;
    end
    case (s_q.st)
      POA_IDLE: begin
        if (s_q.s_start[1]) begin
          s_d.st      = POA_MEAS;
          s_d.ready   = 1'b0;
          s_d.ok      = 1'b1;
          s_d.fail    = 1'b1;
          s_d.onl     = 1'b0;
          s_d.lamp_on = 1'b0;
        end else if (s_q.s_rst[1]) begin
          s_d.st    = POA_STAT;
          s_d.ready = 1'b0;
          clr_all   = 1'b1;
        end
      end
      POA_MEAS: begin
        if (i_win_exit_bad) begin
          s_d.onl = 1'b1;
        end
        if (!s_q.s_start[1]) begin
          s_d.st     = POA_EVAL;
          s_d.ev_cnt = '0;
        end
      end
      POA_EVAL: begin
        s_d.ev_cnt = s_q.ev_cnt + 1'b1;
        if (i_eval_done && s_q.ev_cnt >= CTR_W'(EVAL_CYC)) begin
          s_d.ok   = !i_eval_fail;
          s_d.fail = i_eval_fail;
          if (i_eval_fail && i_ack_fail_en) begin
            s_d.st      = POA_ACKW;
            s_d.lamp_on = 1'b1;
            s_d.lock    = 1'b1;
            s_d.pw_cnt  = '0;
          end else begin
            s_d.st    = POA_IDLE;
            s_d.ready = 1'b1;
          end
        end
      end
      POA_ACKW: begin
        if (s_q.s_ack[1]) begin
          s_d.lock  = 1'b0;
          s_d.buzz  = 1'b0;
          s_d.st    = POA_IDLE;
          s_d.ready = 1'b1;
        end
      end
      POA_STAT: begin
        if (!s_q.s_rst[1]) begin
          s_d.st    = POA_IDLE;
          s_d.ready = 1'b1;
        end
      end
      default: s_d.st = POA_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q       <= '0;
      s_q.st    <= POA_IDLE;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-program statistics, cleared for all programs at once
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NUM_PROG; i++) begin
        part_mem_q[i] <= '0;
        fail_mem_q[i] <= '0;
        pct_mem_q[i]  <= '0;
      end
    end else if (clr_all) begin
      for (int i = 0; i < NUM_PROG; i++) begin
        part_mem_q[i] <= '0;
        fail_mem_q[i] <= '0;
        pct_mem_q[i]  <= '0;
      end
    end else if (i_part_done) begin
      part_mem_q[i_prog_sel] <= part_mem_q[i_prog_sel] + 1'b1;
      fail_mem_q[i_prog_sel] <= fail_mem_q[i_prog_sel] + {{(CNT_W-1){1'b0}}, i_eval_fail};
      pct_mem_q[i_prog_sel]  <= pct_calc(part_mem_q[i_prog_sel] + 1'b1,
                                         fail_mem_q[i_prog_sel] + {{(CNT_W-1){1'b0}}, i_eval_fail});
    end
  end

  function automatic logic [7:0] pct_calc(input logic [CNT_W-1:0] parts,
                                          input logic [CNT_W-1:0] fails);
    logic [CNT_W+7:0] prod;
    prod = fails * {{(CNT_W){1'b0}}, PCT_FULL};
    return (parts == '0) ? 8'h00 : 8'(prod / {8'h00, parts});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_part_cnt                   = part_mem_q[i_prog_sel];
  assign o_fail_cnt                   = fail_mem_q[i_prog_sel];
  assign o_fail_pct                   = pct_mem_q[i_prog_sel];
  assign link.ready                   = s_q.ready;
  assign link.verdict_ok_out          = s_q.ok;
  assign link.verdict_fail_out        = s_q.fail;
  assign link.online_window_violation = s_q.onl;
  assign link.fail_indicator_lamp     = s_q.lamp_on && (!s_q.lock || s_q.flash);
  assign link.lock_out                = s_q.lock;
  assign link.buzzer_out              = s_q.buzz;
  assign link.switch_out              = s_q.sw;
endmodule : poa_instr
`default_nettype wire

// File: src/poa_ctrl.sv
// poa_ctrl: controller end, sequences start, statistics reset and acknowledge
// assumes: instrument outputs arrive from another party and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module poa_ctrl
  import poa_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  poa_if.ctrl       link,
  input  wire logic i_meas_req,
  input  wire logic i_meas_stop,
  input  wire logic i_stat_req,
  input  wire logic i_operator_ack,
  output logic      o_busy,
  output logic      o_fail_seen
);
  typedef enum logic [1:0] {PC_IDLE, PC_MEAS, PC_STAT} poa_pc_t;
  typedef struct packed {
    poa_pc_t    st;
    logic [1:0] s_rdy;
    logic [1:0] s_fail;
    logic       start;
    logic       rst;
    logic       ack;
  } poa_cst_t;

  poa_cst_t c_q;
  poa_cst_t c_d;

  // handshake sequencing on synchronised ready
  always_comb begin
    c_d        = c_q;
    c_d.s_rdy  = {c_q.s_rdy[0], link.ready};
    c_d.s_fail = {c_q.s_fail[0], link.verdict_fail_out};
    c_d.ack    = i_operator_ack;
    case (c_q.st)
      PC_IDLE: begin
        if (c_q.s_rdy[1] && i_meas_req) begin
          c_d.st    = PC_MEAS;
          c_d.start = 1'b1;
        end else if (c_q.s_rdy[1] && i_stat_req) begin
          c_d.st  = PC_STAT;
          c_d.rst = 1'b1;
        end
      end
      PC_MEAS: begin
        if (i_meas_stop) begin
          c_d.start = 1'b0;
          c_d.st    = PC_IDLE;
        end
      end
      PC_STAT: begin
        if (!c_q.s_rdy[1]) begin
          c_d.rst = 1'b0;
          c_d.st  = PC_IDLE;
        end
      end
      default: c_d.st = PC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      c_q    <= '0;
      c_q.st <= PC_IDLE;
    end else begin
      c_q <= c_d;
    end
  end

  assign link.start                        = c_q.start;
  assign link.stat_reset                   = c_q.rst;
  assign link.operator_fail_acknowledge_in = c_q.ack;
  assign o_busy                            = (c_q.st != PC_IDLE);
  assign o_fail_seen                       = c_q.s_fail[1];
endmodule : poa_ctrl
`default_nettype wire

// File: testbench/poa_checker.sv
// poa_checker: timing relations on the lines between the two ends
// assumes: instantiated beside the interface, every signal on i_mclk
`timescale 1ns/1ps
`default_nettype none
module poa_checker (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic start,
  input wire logic stat_reset,
  input wire logic operator_fail_acknowledge_in,
  input wire logic ready,
  input wire logic verdict_ok_out,
  input wire logic verdict_fail_out,
  input wire logic online_window_violation,
  input wire logic fail_indicator_lamp,
  input wire logic lock_out,
  input wire logic buzzer_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // single clock domain
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // measurement phase and start
  meas_ready_a: assert property (verdict_ok_out && verdict_fail_out |-> !ready)
    else $error("both verdicts high while ready");
  start_clear_a: assert property ($rose(start) |-> ready ##[1:4]
    (!ready && verdict_ok_out && verdict_fail_out && !online_window_violation))
    else $error("measurement start not answered");
  lamp_start_a: assert property ($rose(start) |-> ##[1:4] !fail_indicator_lamp)
    else $error("lamp still on after start");
  viol_hold_a: assert property ($fell(online_window_violation) |-> start)
    else $error("violation flag dropped outside a start");
  // acknowledge outputs
  lock_verdict_a: assert property (lock_out |-> verdict_fail_out && !verdict_ok_out && !ready)
    else $error("lock without fail verdict");
  buzz_lock_a: assert property (buzzer_out |-> lock_out)
    else $error("buzzer without lock");
  buzz_start_a: assert property ($rose(lock_out) |-> ##1 buzzer_out)
    else $error("buzzer not started with lock");
  ack_release_a: assert property ($rose(operator_fail_acknowledge_in) && lock_out |->
    ##[1:4] (ready && !lock_out && !buzzer_out && fail_indicator_lamp))
    else $error("acknowledge not answered");
  // statistics reset handshake
  stat_drop_a: assert property ($rose(stat_reset) |-> ready ##[1:4] !ready)
    else $error("ready kept high on statistics reset");
  stat_back_a: assert property ($fell(stat_reset) |-> !ready ##[1:5] ready)
    else $error("ready not back after statistics reset");
endmodule // poa_checker
`default_nettype wire

// File: testbench/testbench.sv
// testbench: joins instrument and controller ends, drives both user sides
// assumes: 40 MHz i_mclk, results compared by a queue monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import poa_pkg::*;
  typedef struct {int sel; logic [15:0] exp; logic [15:0] msk;} poa_note_t;
  logic                   i_mclk = 1'b0;
  logic                   i_arst_n = 1'b0;
  logic                   ack_en = 1'b0, ev_done = 1'b0, ev_fail = 1'b0, win_bad = 1'b0;
  logic                   trig = 1'b0, part_done = 1'b0, op_ack = 1'b0;
  logic                   meas_req = 1'b0, meas_stop = 1'b0, stat_req = 1'b0;
  logic signed [RD_W-1:0] x_abs = 16'h0, x_trig = 16'h0, y = 16'h0;
  poa_sw_cfg_t            sw_cfg [NUM_SW];
  logic [3:0]             prog = 4'h0;
  logic [CNT_W-1:0]       part_cnt, fail_cnt;
  logic [7:0]             fail_pct;
  logic                   busy, fail_seen;
  int                     mismatches = 0, check_count = 0;
  poa_note_t              notes [$];
  event                   look;
  string                  nm [5] = '{"switch_out", "part_cnt", "fail_cnt", "fail_pct", "lines"};
  poa_if link ();
  ////////////////////////////////////////////////////////////////////////////////
  // both ends and the checker
  poa_instr u_poa_instr (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link),
    .i_ack_fail_en(ack_en), .i_eval_done(ev_done), .i_eval_fail(ev_fail),
    .i_win_exit_bad(win_bad), .i_trig_seen(trig), .i_x_abs(x_abs), .i_x_trig(x_trig),
    .i_y(y), .i_sw_cfg(sw_cfg), .i_prog_sel(prog), .i_part_done(part_done),
    .o_part_cnt(part_cnt), .o_fail_cnt(fail_cnt), .o_fail_pct(fail_pct));
  poa_ctrl u_poa_ctrl (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link),
    .i_meas_req(meas_req), .i_meas_stop(meas_stop), .i_stat_req(stat_req),
    .i_operator_ack(op_ack), .o_busy(busy), .o_fail_seen(fail_seen));
  poa_checker u_poa_checker (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .start(link.start),
    .stat_reset(link.stat_reset), .operator_fail_acknowledge_in(link.operator_fail_acknowledge_in),
    .ready(link.ready), .verdict_ok_out(link.verdict_ok_out),
    .verdict_fail_out(link.verdict_fail_out), .online_window_violation(link.online_window_violation),
    .fail_indicator_lamp(link.fail_indicator_lamp), .lock_out(link.lock_out),
    .buzzer_out(link.buzzer_out));
  // 25 ns clock
  always #12.5 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: compares each noted expectation against the outputs
  always @(look) begin : monitor
    poa_note_t   n;
    logic [15:0] act;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: act = {10'h0, link.switch_out};
        1: act = part_cnt;
        2: act = fail_cnt;
        3: act = {8'h0, fail_pct};
        default: act = {7'h0, fail_seen, busy, link.ready, link.verdict_ok_out,
          link.verdict_fail_out, link.online_window_violation, link.fail_indicator_lamp,
          link.lock_out, link.buzzer_out};
      endcase
      check_count++;
      if (((act ^ n.exp) & n.msk) !== 16'h0) begin
        $display("unexpected %s exp %h seen %h", nm[n.sel], n.exp, act);
        mismatches++;
      end
    end
  end
  // shared steps and waits
  task automatic step;
    @(posedge i_mclk);
    #2;
  endtask
  task automatic note(input int sel, input logic [15:0] exp, input logic [15:0] msk);
    notes.push_back('{sel, exp, msk});
    ->look;
  endtask
  task automatic wait_lvl(input logic lvl, input logic or_lock);
    int n;
    n = 0;
    while (link.ready !== lvl && !(or_lock && link.lock_out === 1'b1) && n < 3000) begin
      step;
      n++;
    end
    if (n == 3000) begin
      $display("unexpected ready exp %h seen %h", lvl, link.ready);
      mismatches++;
    end
  endtask
  // random readings and settings against the threshold outputs
  task automatic sw_test(input logic meas);
    logic [15:0]            e;
    logic signed [RD_W-1:0] rd;
    for (int k = 0; k < 4; k++) begin
      x_abs = 16'($urandom);
      x_trig = 16'($urandom);
      y = 16'($urandom);
      trig = 1'($urandom);
      e = 16'h0;
      foreach (sw_cfg[i]) begin
        sw_cfg[i] = poa_sw_cfg_t'($urandom);
        rd = sw_cfg[i].chan_y ? y : (sw_cfg[i].ref_trig ? x_trig : x_abs);
        if (sw_cfg[i].chan_y || !sw_cfg[i].ref_trig || (meas && trig)) begin
          e[i] = (rd > $signed(sw_cfg[i].thresh)) == sw_cfg[i].act_high;
        end else begin
          e[i] = !sw_cfg[i].act_high;
        end
      end
      step;
      step;
      note(0, e, 16'h003f);
    end
  endtask
  // one measurement with verdict, acknowledge mode and window fault
  task automatic meas(input logic fl, input logic ae, input logic bad);
    ack_en = ae;
    ev_fail = fl;
    meas_req = 1'b1;
    wait_lvl(1'b0, 1'b0);
    note(4, 16'h00b0, 16'h00ff);
    sw_test(1'b1);
    win_bad = bad;
    step;
    win_bad = 1'b0;
    step;
    step;
    note(4, {8'h0, 1'b1, 3'h0, bad, 3'h0}, 16'h0088);
    meas_req = 1'b0;
    meas_stop = 1'b1;
    ev_done = 1'b1;
    wait_lvl(1'b1, 1'b1);
    if (fl && ae) begin
      note(4, 16'h0112, 16'h01f2);
      op_ack = 1'b1;
      wait_lvl(1'b1, 1'b0);
      note(4, 16'h0154, 16'h01f7);
      op_ack = 1'b0;
    end else begin
      note(4, {9'h0, 1'b1, !fl, fl, bad, 3'h0}, 16'h00ff);
    end
    meas_stop = 1'b0;
    ev_done = 1'b0;
    step;
    step;
  endtask
  // counts of one program, then a clear of every program
  task automatic stat_clear;
    prog = 4'h3;
    ev_fail = 1'b1;
    part_done = 1'b1;
    step;
    part_done = 1'b0;
    step;
    note(1, 16'h0001, 16'hffff);
    note(2, 16'h0001, 16'hffff);
    note(3, 16'h0064, 16'h00ff);
    stat_req = 1'b1;
    wait_lvl(1'b0, 1'b0);
    note(4, 16'h0080, 16'h00c0);
    stat_req = 1'b0;
    wait_lvl(1'b1, 1'b0);
    for (int p = 0; p < 16; p++) begin
      prog = 4'(p);
      step;
      note(1, 16'h0, 16'hffff);
      note(2, 16'h0, 16'hffff);
      note(3, 16'h0, 16'h00ff);
      step;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    foreach (sw_cfg[i]) sw_cfg[i] = '0;
    void'($urandom(42));
    repeat (5) @(posedge i_mclk);
    #2;
    i_arst_n = 1'b1;
    step;
    sw_test(1'b0);
    stat_clear;
    meas(1'b1, 1'b1, 1'b1);
    meas(1'b0, 1'b1, 1'b0);
    meas(1'b1, 1'b0, 1'b0);
    meas(1'b0, 1'b0, 1'b1);
    give_verdict;
  end
  // watchdog against a hang
  initial begin : watchdog
    #(25 * 40000);
    mismatches++;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
